/* msv_status_vectors.sv */
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "msv_map.svh"

module msv_status_vectors
  import msv_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // mac datapath side
  input wire logic tx_done_in,
  input wire msv_tx_report_t tx_report_in,
  input wire logic rx_done_in,
  input wire msv_rx_report_t rx_report_in,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  // reset release synchroniser
  logic rst_meta_n;
  logic rst_n;

  // captured vectors
  logic [31:0] tx_low;
  logic [31:0] tx_high;
  logic [31:0] rx_vec;
  logic [31:0] next_tx_low;
  logic [31:0] next_tx_high;
  logic [31:0] next_rx_vec;

  // write channel state
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [1:0] bresp;
  logic bvalid;

  // read channel state
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;

  // decoded helper terms
  logic tx_bcast;
  logic tx_group;
  logic tx_ctrl;
  logic tx_xdefer;
  logic tx_xcoll;
  logic rx_bcast;
  logic rx_group;
  logic rx_ctrl;
  logic rx_crc_bad;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;
  logic wr_mapped;

  // asynchronous assert, two-flop release
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // transmit decode terms
  always_comb begin
    // all-ones destination is broadcast
    tx_bcast = &tx_report_in.dest_addr;
    // group bit of first octet on the wire
    tx_group = tx_report_in.dest_addr[40];
    tx_ctrl = (tx_report_in.len_type == `MSV_CTRL_TYPE);
    // defer limit depends on link speed
    if (tx_report_in.speed_100) begin
      tx_xdefer = (tx_report_in.defer_time > `MSV_DEFER_NIBBLES);
    end else begin
      tx_xdefer = (tx_report_in.defer_time > `MSV_DEFER_BITS);
    end
    tx_xcoll = (tx_report_in.collisions >= `MSV_MAX_COLLISIONS);
  end

  // transmit vector assembly
  always_comb begin
    next_tx_low = `MSV_VEC_RESET;
    next_tx_high = `MSV_VEC_RESET;
    next_tx_low[`MSV_T0_CRC] = (tx_report_in.fcs_sent != tx_report_in.fcs_calc);
    // length mismatch only counts for a length, not a type
    next_tx_low[`MSV_T0_LEN_CHK] = (tx_report_in.len_type < `MSV_TYPE_MIN)
      && (tx_report_in.len_type != tx_report_in.data_count);
    // type values also compare, so this is informative only
    next_tx_low[`MSV_T0_LEN_RANGE] = (tx_report_in.len_type > `MSV_TX_MAX_LEN);
    next_tx_low[`MSV_T0_DONE] = tx_report_in.completed;
    next_tx_low[`MSV_T0_MCAST] = tx_group && !tx_bcast;
    next_tx_low[`MSV_T0_BCAST] = tx_bcast;
    next_tx_low[`MSV_T0_DEFER] = (tx_report_in.defer_time != 16'h0000) && !tx_xdefer;
    next_tx_low[`MSV_T0_XDEFER] = tx_xdefer;
    next_tx_low[`MSV_T0_XCOLL] = tx_xcoll;
    // late means a collision past the slot window
    next_tx_low[`MSV_T0_LATE] = (tx_report_in.collisions != 5'h00)
      && (tx_report_in.coll_offset > `MSV_COLL_WINDOW);
    next_tx_low[`MSV_T0_GIANT] = tx_report_in.frame_bytes[16];
    next_tx_low[`MSV_T0_UNDERRUN] = tx_report_in.underrun;
    next_tx_low[`MSV_T0_TOTAL_MSB:`MSV_T0_TOTAL_LSB] = tx_report_in.total_bytes;
    next_tx_low[`MSV_T0_CTRL] = tx_ctrl;
    next_tx_low[`MSV_T0_PAUSE] = tx_ctrl && (tx_report_in.opcode == `MSV_PAUSE_OPCODE);
    next_tx_low[`MSV_T0_BACKP] = tx_report_in.backpressure;
    next_tx_low[`MSV_T0_VLAN] = (tx_report_in.len_type == `MSV_VLAN_TAG);
    // low sixteen bits only; overflow shows as giant
    next_tx_high[`MSV_T1_BYTES_MSB:0] = tx_report_in.frame_bytes[15:0];
    // sixteen collisions wraps to zero in four bits
    next_tx_high[`MSV_T1_COLL_MSB:`MSV_T1_COLL_LSB] = tx_report_in.collisions[3:0];
  end

  // receive decode terms
  always_comb begin
    rx_bcast = &rx_report_in.dest_addr;
    rx_group = rx_report_in.dest_addr[40];
    rx_ctrl = (rx_report_in.len_type == `MSV_CTRL_TYPE);
    rx_crc_bad = (rx_report_in.fcs_sent != rx_report_in.fcs_calc);
  end

  // receive vector assembly
  always_comb begin
    next_rx_vec = `MSV_VEC_RESET;
    next_rx_vec[`MSV_R_BYTES_MSB:0] = rx_report_in.byte_count;
    next_rx_vec[`MSV_R_DROPPED] = rx_report_in.dropped;
    next_rx_vec[`MSV_R_SHORT] = rx_report_in.short_event;
    next_rx_vec[`MSV_R_CARRIER] = rx_report_in.carrier_event;
    next_rx_vec[`MSV_R_CODE_VIOL] = rx_report_in.code_violation;
    next_rx_vec[`MSV_R_CRC] = rx_crc_bad;
    next_rx_vec[`MSV_R_LEN_CHK] = (rx_report_in.len_type < `MSV_TYPE_MIN)
      && (rx_report_in.len_type != rx_report_in.data_count);
    next_rx_vec[`MSV_R_LEN_RANGE] = (rx_report_in.len_type > `MSV_RX_MAX_LEN);
    // good only with matching crc and clean symbols
    next_rx_vec[`MSV_R_OK] = !rx_crc_bad && !rx_report_in.code_violation;
    next_rx_vec[`MSV_R_MCAST] = rx_group && !rx_bcast;
    next_rx_vec[`MSV_R_BCAST] = rx_bcast;
    // stray trailing bits, flagged as one bit when the three-bit count is nonzero
    next_rx_vec[`MSV_R_DRIBBLE] = (rx_report_in.dribble_bits != 3'h0);
    next_rx_vec[`MSV_R_CTRL] = rx_ctrl;
    next_rx_vec[`MSV_R_PAUSE] = rx_ctrl && (rx_report_in.opcode == `MSV_PAUSE_OPCODE);
    next_rx_vec[`MSV_R_UNSUP] = rx_ctrl && (rx_report_in.opcode != `MSV_PAUSE_OPCODE);
    next_rx_vec[`MSV_R_VLAN] = (rx_report_in.len_type == `MSV_VLAN_TAG);
  end

  // both transmit words load on the same edge
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_low <= `MSV_VEC_RESET;
      tx_high <= `MSV_VEC_RESET;
    end else if (tx_done_in) begin
      tx_low <= next_tx_low;
      tx_high <= next_tx_high;
    end
  end

  // receive word loads at frame end
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_vec <= `MSV_VEC_RESET;
    end else if (rx_done_in) begin
      rx_vec <= next_rx_vec;
    end
  end

  // bus handshakes
  assign s_axi_awready_out = !aw_held && !bvalid;
  assign s_axi_wready_out = !w_held && !bvalid;
  assign s_axi_arready_out = !rvalid;
  assign aw_hs = s_axi_awvalid_in && s_axi_awready_out;
  assign w_hs = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;

  // write address and data taken in either order
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_held && w_held) begin
      // both present: response is issued now
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (w_hs) begin
        w_held <= 1'b1;
      end
    end
  end

  // write decode: data is discarded, registers are read only
  always_comb begin
    if (aw_addr == `MSV_TX_LOW_ADDR) begin
      wr_mapped = 1'b1;
    end else if (aw_addr == `MSV_TX_HIGH_ADDR) begin
      wr_mapped = 1'b1;
    end else if (aw_addr == `MSV_RX_ADDR) begin
      wr_mapped = 1'b1;
    end else begin
      wr_mapped = 1'b0;
    end
  end

  // write response
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= `MSV_RESP_OKAY;
    end else if (aw_held && w_held) begin
      bvalid <= 1'b1;
      // mapped writes accepted and ignored
      bresp <= wr_mapped ? `MSV_RESP_OKAY : `MSV_RESP_DECERR;
    end else if (bvalid && s_axi_bready_in) begin
      bvalid <= 1'b0;
    end
  end
  assign s_axi_bvalid_out = bvalid;
  assign s_axi_bresp_out = bresp;

  // read decode
  always_comb begin
    if (s_axi_araddr_in == `MSV_TX_LOW_ADDR) begin
      rd_word = tx_low;
      rd_resp = `MSV_RESP_OKAY;
    end else if (s_axi_araddr_in == `MSV_TX_HIGH_ADDR) begin
      rd_word = tx_high;
      rd_resp = `MSV_RESP_OKAY;
    end else if (s_axi_araddr_in == `MSV_RX_ADDR) begin
      rd_word = rx_vec;
      rd_resp = `MSV_RESP_OKAY;
    end else begin
      // unmapped: zero data, decode error
      rd_word = `MSV_VEC_RESET;
      rd_resp = `MSV_RESP_DECERR;
    end
  end

  // read data captured at address acceptance
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= `MSV_VEC_RESET;
      rresp <= `MSV_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_resp;
    end else if (rvalid && s_axi_rready_in) begin
      rvalid <= 1'b0;
    end
  end
  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rdata_out = rdata;
  assign s_axi_rresp_out = rresp;

  // assertions
  default clocking msv_cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n);

  chk_tx_atomic_load: assert property (
    tx_done_in |=> (tx_low == $past(next_tx_low)) && (tx_high == $past(next_tx_high)))
    else $error("transmit words not loaded together");

  chk_tx_hold_idle: assert property (
    !tx_done_in |=> $stable(tx_low) && $stable(tx_high))
    else $error("transmit words changed without a frame");

  chk_rx_hold_idle: assert property (
    !rx_done_in |=> $stable(rx_vec))
    else $error("receive word changed without a frame");

  chk_tx_crc_flag: assert property (
    tx_done_in && (tx_report_in.fcs_sent != tx_report_in.fcs_calc) |=> tx_low[`MSV_T0_CRC])
    else $error("transmit crc mismatch not flagged");

  chk_tx_len_range: assert property (
    tx_done_in |=> tx_low[`MSV_T0_LEN_RANGE] == ($past(tx_report_in.len_type) > `MSV_TX_MAX_LEN))
    else $error("transmit length range bit wrong");

  chk_defer_exclusive: assert property (
    !(tx_low[`MSV_T0_DEFER] && tx_low[`MSV_T0_XDEFER]))
    else $error("defer and excessive defer both set");

  chk_tx_bytes: assert property (
    tx_done_in |=> tx_high[`MSV_T1_BYTES_MSB:0] == $past(tx_report_in.frame_bytes[15:0]))
    else $error("transmit byte count wrong");

  chk_tx_unused: assert property (
    tx_high[31:20] == 12'h000 && rx_vec[31] == 1'b0)
    else $error("unused bits not zero");

  chk_rx_ok_flag: assert property (
    rx_vec[`MSV_R_OK] |-> !rx_vec[`MSV_R_CRC] && !rx_vec[`MSV_R_CODE_VIOL])
    else $error("receive ok with crc or code error");

  chk_rx_vlan: assert property (
    rx_done_in |=> rx_vec[`MSV_R_VLAN] == ($past(rx_report_in.len_type) == `MSV_VLAN_TAG))
    else $error("receive vlan bit wrong");

  chk_rx_bcast_mcast: assert property (
    !(rx_vec[`MSV_R_MCAST] && rx_vec[`MSV_R_BCAST]))
    else $error("multicast and broadcast both set");

  chk_read_answer: assert property (
    ar_hs && (s_axi_araddr_in == `MSV_RX_ADDR) && !rx_done_in
      |=> rvalid && (rdata == rx_vec) && (rresp == `MSV_RESP_OKAY))
    else $error("receive word read answered wrongly");

  chk_write_answer: assert property (
    aw_held && w_held |=> bvalid && ($stable(tx_low) || $past(tx_done_in)))
    else $error("write response missing or write took effect");

  cov_tx_frame: cover property (tx_done_in ##1 tx_low[`MSV_T0_DONE]);
  cov_rx_good: cover property (rx_done_in ##1 rx_vec[`MSV_R_OK]);
  cov_read_tx: cover property (ar_hs && s_axi_araddr_in == `MSV_TX_HIGH_ADDR ##1 rvalid);
  cov_write_drop: cover property (aw_held && w_held ##1 bvalid);

endmodule
`default_nettype wire

/* msv_map.svh */
`ifndef MSV_MAP_SVH
`define MSV_MAP_SVH
// register byte addresses
`define MSV_TX_LOW_ADDR 32'hFFE00158
`define MSV_TX_HIGH_ADDR 32'hFFE0015C
`define MSV_RX_ADDR 32'hFFE00160
// axi response codes
`define MSV_RESP_OKAY 2'h0
`define MSV_RESP_DECERR 2'h3
// reset values
`define MSV_VEC_RESET 32'h00000000
// frame field thresholds
`define MSV_TX_MAX_LEN 16'h05DC
`define MSV_RX_MAX_LEN 16'h05EE
`define MSV_TYPE_MIN 16'h0600
`define MSV_VLAN_TAG 16'h8100
`define MSV_CTRL_TYPE 16'h8808
`define MSV_PAUSE_OPCODE 16'h0001
`define MSV_DEFER_NIBBLES 16'h17B7
`define MSV_DEFER_BITS 16'h5EDF
`define MSV_MAX_COLLISIONS 5'h10
`define MSV_COLL_WINDOW 16'h0200
// transmit low word field positions
`define MSV_T0_CRC 0
`define MSV_T0_LEN_CHK 1
`define MSV_T0_LEN_RANGE 2
`define MSV_T0_DONE 3
`define MSV_T0_MCAST 4
`define MSV_T0_BCAST 5
`define MSV_T0_DEFER 6
`define MSV_T0_XDEFER 7
`define MSV_T0_XCOLL 8
`define MSV_T0_LATE 9
`define MSV_T0_GIANT 10
`define MSV_T0_UNDERRUN 11
`define MSV_T0_TOTAL_LSB 12
`define MSV_T0_TOTAL_MSB 27
`define MSV_T0_CTRL 28
`define MSV_T0_PAUSE 29
`define MSV_T0_BACKP 30
`define MSV_T0_VLAN 31
// transmit high word field positions
`define MSV_T1_BYTES_MSB 15
`define MSV_T1_COLL_LSB 16
`define MSV_T1_COLL_MSB 19
// receive word field positions
`define MSV_R_BYTES_MSB 15
`define MSV_R_DROPPED 16
`define MSV_R_SHORT 17
`define MSV_R_CARRIER 18
`define MSV_R_CODE_VIOL 19
`define MSV_R_CRC 20
`define MSV_R_LEN_CHK 21
`define MSV_R_LEN_RANGE 22
`define MSV_R_OK 23
`define MSV_R_MCAST 24
`define MSV_R_BCAST 25
`define MSV_R_DRIBBLE 26
`define MSV_R_CTRL 27
`define MSV_R_PAUSE 28
`define MSV_R_UNSUP 29
`define MSV_R_VLAN 30
`endif

/* msv_pkg.sv */
package msv_pkg;
  // facts about one finished transmit frame
  typedef struct packed {
    logic [31:0] fcs_sent;
    logic [31:0] fcs_calc;
    logic [15:0] len_type;
    logic [15:0] data_count;
    logic [47:0] dest_addr;
    logic [15:0] opcode;
    logic [15:0] defer_time;
    logic speed_100;
    logic [4:0] collisions;
    logic [15:0] coll_offset;
    logic completed;
    logic underrun;
    logic backpressure;
    logic [15:0] total_bytes;
    logic [16:0] frame_bytes;
  } msv_tx_report_t;
  // facts about one finished receive frame
  typedef struct packed {
    logic [31:0] fcs_sent;
    logic [31:0] fcs_calc;
    logic [15:0] len_type;
    logic [15:0] data_count;
    logic [47:0] dest_addr;
    logic [15:0] opcode;
    logic [15:0] byte_count;
    logic dropped;
    logic short_event;
    logic carrier_event;
    logic code_violation;
    logic [2:0] dribble_bits;
  } msv_rx_report_t;
endpackage

/* msv_mac_model.sv */
`timescale 1ns/10ps
`default_nettype none
// behavioural model of the mac datapath reporting finished frames
module msv_mac_model
  import msv_pkg::*;
(
  input wire logic clk_in,
  output var logic tx_done_out,
  output var msv_tx_report_t tx_report_out,
  output var logic rx_done_out,
  output var msv_rx_report_t rx_report_out
);
  // idle at time zero: no strobe, report lines show junk
  initial begin
    tx_done_out = 1'b0;
    rx_done_out = 1'b0;
    tx_report_out = '1;
    rx_report_out = '1;
  end

  // one transmit frame: report valid in the strobe cycle only
  task automatic tx_frame(input msv_tx_report_t r);
    @(posedge clk_in);
    tx_report_out <= r;
    tx_done_out <= 1'b1;
    @(posedge clk_in);
    // datapath quiet again before software looks
    tx_done_out <= 1'b0;
    // lines no longer hold the report, so late capture shows up
    tx_report_out <= ~r;
  endtask

  // one receive frame, same shape as transmit
  task automatic rx_frame(input msv_rx_report_t r);
    @(posedge clk_in);
    rx_report_out <= r;
    rx_done_out <= 1'b1;
    @(posedge clk_in);
    rx_done_out <= 1'b0;
    rx_report_out <= ~r;
  endtask
endmodule
`default_nettype wire

/* msv_status_vectors_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "msv_map.svh"
module msv_status_vectors_bench
  import msv_pkg::*;
;
  logic clk_sys; // 125 MHz clock
  logic reset_n; // active low reset
  logic tx_done, rx_done; // strobes from the mac model
  msv_tx_report_t tx_report;
  msv_rx_report_t rx_report;
  logic [31:0] awaddr, wdata, araddr, rdata; // bus payloads
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int mismatches, n_tests, cycles; // verdict counters and timeout

  msv_status_vectors dut_u (
    .clk_sys_in(clk_sys), .reset_n_in(reset_n),
    .tx_done_in(tx_done), .tx_report_in(tx_report),
    .rx_done_in(rx_done), .rx_report_in(rx_report),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready)
  );

  msv_mac_model mac_u (
    .clk_in(clk_sys), .tx_done_out(tx_done), .tx_report_out(tx_report),
    .rx_done_out(rx_done), .rx_report_out(rx_report)
  );

  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // hang guard: about 115 cycles needed, ceiling well above
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end

  // counts and verdict, then stop
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // axi4-lite read, judged on data and response
  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    check(rdata, d);
    check({30'h0, rresp}, {30'h0, r});
    rready <= 1'b0;
  endtask

  // axi4-lite write, address and data offered together
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      // release each channel at its own handshake
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(posedge clk_sys); while (!bvalid);
    check({30'h0, bresp}, {30'h0, r});
    bready <= 1'b0;
  endtask

  // all three words clear after reset
  task automatic t_reset_values();
    rd(`MSV_TX_LOW_ADDR, 32'h0, `MSV_RESP_OKAY);
    rd(`MSV_TX_HIGH_ADDR, 32'h0, `MSV_RESP_OKAY);
    rd(`MSV_RX_ADDR, 32'h0, `MSV_RESP_OKAY);
    $display("test reset_values done");
  endtask

  // crc, length, multicast, defer at limit, backpressure
  task automatic t_tx_errors();
    mac_u.tx_frame('{32'h1, 32'h2, 16'h0040, 16'h0030, 48'h01005E000001, 16'h0,
      16'h17B7, 1'b1, 5'h03, 16'h0200, 1'b1, 1'b0, 1'b1, 16'h0123, 17'h00100});
    rd(`MSV_TX_LOW_ADDR, 32'h4012305B, `MSV_RESP_OKAY);
    rd(`MSV_TX_HIGH_ADDR, 32'h00030100, `MSV_RESP_OKAY);
    $display("test tx_errors done");
  endtask

  // two frames in a row; the later one with every limit crossed
  task automatic t_tx_limits();
    mac_u.tx_frame('{32'h3, 32'h4, 16'h0020, 16'h0010, 48'h0, 16'h0,
      16'h0, 1'b1, 5'h0, 16'h0, 1'b1, 1'b0, 1'b0, 16'h0001, 17'h00001});
    mac_u.tx_frame('{32'h5, 32'h5, 16'h8100, 16'h0010, 48'hFFFFFFFFFFFF, 16'h0,
      16'h17B8, 1'b1, 5'h10, 16'h0201, 1'b0, 1'b1, 1'b0, 16'hFFFF, 17'h10005});
    rd(`MSV_TX_LOW_ADDR, 32'h8FFFFFA4, `MSV_RESP_OKAY);
    rd(`MSV_TX_HIGH_ADDR, 32'h00000005, `MSV_RESP_OKAY);
    $display("test tx_limits done");
  endtask

  // pause control frame at 10 Mbps, defer just below excess
  task automatic t_tx_pause();
    // 10 Mbps defer one past the limit, length exactly at 1500
    mac_u.tx_frame('{32'h8, 32'h8, 16'h05DC, 16'h05DC, 48'h0, 16'h0,
      16'h5EE0, 1'b0, 5'h00, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h05DC, 17'h005DC});
    rd(`MSV_TX_LOW_ADDR, 32'h005DC088, `MSV_RESP_OKAY);
    rd(`MSV_TX_HIGH_ADDR, 32'h000005DC, `MSV_RESP_OKAY);
    mac_u.tx_frame('{32'h7, 32'h7, 16'h8808, 16'h0040, 48'h020000000001, 16'h0001,
      16'h5EDF, 1'b0, 5'h01, 16'h0010, 1'b1, 1'b0, 1'b0, 16'h0040, 17'h00040});
    rd(`MSV_TX_LOW_ADDR, 32'h3004004C, `MSV_RESP_OKAY);
    rd(`MSV_TX_HIGH_ADDR, 32'h00010040, `MSV_RESP_OKAY);
    $display("test tx_pause done");
  endtask

  // receive frames covering every flag; transmit low word untouched
  task automatic t_rx_frames();
    mac_u.rx_frame('{32'h1, 32'h2, 16'h05EF, 16'h0010, 48'h010000000000, 16'h0,
      16'h05EE, 1'b1, 1'b1, 1'b1, 1'b0, 3'h0});
    rd(`MSV_RX_ADDR, 32'h017705EE, `MSV_RESP_OKAY);
    mac_u.rx_frame('{32'h9, 32'h9, 16'h8100, 16'h0040, 48'hFFFFFFFFFFFF, 16'h0,
      16'h0040, 1'b0, 1'b0, 1'b0, 1'b0, 3'h3});
    rd(`MSV_RX_ADDR, 32'h46C00040, `MSV_RESP_OKAY);
    mac_u.rx_frame('{32'h9, 32'h9, 16'h8808, 16'h0040, 48'h0, 16'h0002,
      16'h0040, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0});
    rd(`MSV_RX_ADDR, 32'h28480040, `MSV_RESP_OKAY);
    mac_u.rx_frame('{32'h9, 32'h9, 16'h8808, 16'h0040, 48'h0, 16'h0001,
      16'h0040, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0});
    rd(`MSV_RX_ADDR, 32'h18C00040, `MSV_RESP_OKAY);
    rd(`MSV_TX_LOW_ADDR, 32'h3004004C, `MSV_RESP_OKAY);
    $display("test rx_frames done");
  endtask

  // writes ignored, unmapped address refused
  task automatic t_bus_access();
    wr(`MSV_TX_LOW_ADDR, 32'hFFFFFFFF, `MSV_RESP_OKAY);
    rd(`MSV_TX_LOW_ADDR, 32'h3004004C, `MSV_RESP_OKAY);
    wr(`MSV_RX_ADDR, 32'h0, `MSV_RESP_OKAY);
    rd(`MSV_RX_ADDR, 32'h18C00040, `MSV_RESP_OKAY);
    wr(32'hFFE00164, 32'h1, `MSV_RESP_DECERR);
    rd(32'hFFE00164, 32'h0, `MSV_RESP_DECERR);
    $display("test bus_access done");
  endtask

  // reset in mid-run clears every captured word
  task automatic t_mid_reset();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    // internal reset leaves after the synchroniser
    repeat (3) @(posedge clk_sys);
    rd(`MSV_TX_LOW_ADDR, 32'h0, `MSV_RESP_OKAY);
    rd(`MSV_TX_HIGH_ADDR, 32'h0, `MSV_RESP_OKAY);
    rd(`MSV_RX_ADDR, 32'h0, `MSV_RESP_OKAY);
    $display("test mid_reset done");
  endtask

  // main sequence
  initial begin
    reset_n = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    // internal reset leaves after the synchroniser
    repeat (3) @(posedge clk_sys);
    t_reset_values();
    t_tx_errors();
    t_tx_limits();
    t_tx_pause();
    t_rx_frames();
    t_bus_access();
    t_mid_reset();
    end_sim();
  end
endmodule
`default_nettype wire
